// ### rtl/djkff_cell.sv
// Purpose: One J-K storage cell with forced preset and clear
// Assumes: fall_in is a one-cycle strobe for a falling edge_clock
// Notes:   Both outputs are flip-flops; forcing acts on the next core clock

`timescale 1ns/1ps

module djkff_cell
	import djkff_pkg::*;
(
	// Clock and reset
	input  wire logic core_clk_in,
	input  wire logic rst_in,
	// Synchronous controls
	input  wire logic fall_in,
	input  wire logic set_input_in,
	input  wire logic reset_input_in,
	// Effective asynchronous controls, active low
	input  wire logic async_set_n_in,
	input  wire logic async_clear_n_in,
	// Outputs
	output logic      true_out,
	output logic      comp_out
);

	djkff_act_e act;
	logic       prior_state;
	logic       next_true;
	logic       next_comp;
	wire        force_set;
	wire        force_clear;
	wire        force_both;

	// Decode of the forcing inputs
	assign force_set   = !async_set_n_in && async_clear_n_in;
	assign force_clear = async_set_n_in && !async_clear_n_in;
	assign force_both  = !async_set_n_in && !async_clear_n_in;
	assign prior_state = true_out;

	// Action selected by set_input and reset_input
	always_comb
	begin
		act = djkff_act_e'({set_input_in, reset_input_in});
	end

	// Next output levels
	always_comb
	begin
		next_true = true_out;
		next_comp = comp_out;
		if (force_both)
		begin
			next_true = 1'b1;
			next_comp = 1'b1;
		end
		else if (force_set)
		begin
			next_true = 1'b1;
			next_comp = 1'b0;
		end
		else if (force_clear)
		begin
			next_true = 1'b0;
			next_comp = 1'b1;
		end
		else if (fall_in)
		begin
			case (act)
				DJKFF_ACT_HOLD:   next_true = prior_state;
				DJKFF_ACT_RESET:  next_true = 1'b0;
				DJKFF_ACT_SET:    next_true = 1'b1;
				DJKFF_ACT_TOGGLE: next_true = !prior_state;
				default:          next_true = prior_state;
			endcase
			next_comp = !next_true;
		end
		else
		begin
			// Leaving the both-low state restores a proper complement
			next_comp = !true_out;
		end
	end

	// Output registers
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			true_out <= DJKFF_TRUE_RST;
			comp_out <= DJKFF_COMP_RST;
		end
		else
		begin
			true_out <= next_true;
			comp_out <= next_comp;
		end
	end

endmodule

// ### rtl/djkff_pkg.sv
// Purpose: Shared constants and types for the dual J-K flip-flop block
// Assumes: All inputs are synchronous to core_clk_in
// Notes:   Build options select which asynchronous inputs exist

package djkff_pkg;

	// ===========================================================
	// Build options
	// ===========================================================
	// Bit 0 enables the clear input, bit 1 enables the preset input
	typedef enum logic [1:0]
	{
		DJKFF_OPT_CLEAR  = 2'b01,
		DJKFF_OPT_PRESET = 2'b10,
		DJKFF_OPT_BOTH   = 2'b11
	} djkff_opt_e;

	localparam int DJKFF_OPT_CLEAR_BIT  = 0;
	localparam int DJKFF_OPT_PRESET_BIT = 1;

	// ===========================================================
	// Synchronous actions on a falling edge_clock
	// ===========================================================
	typedef enum logic [1:0]
	{
		DJKFF_ACT_HOLD   = 2'b00,
		DJKFF_ACT_RESET  = 2'b01,
		DJKFF_ACT_SET    = 2'b10,
		DJKFF_ACT_TOGGLE = 2'b11
	} djkff_act_e;

	// ===========================================================
	// Reset values and levels
	// ===========================================================
	localparam logic DJKFF_TRUE_RST  = 1'b0;
	localparam logic DJKFF_COMP_RST  = 1'b1;
	localparam logic DJKFF_CLK_RST   = 1'b0;
	localparam logic DJKFF_INACTIVE  = 1'b1;
	localparam int   DJKFF_NUM_FLOPS = 2;

endpackage

// ### rtl/djkff_top.sv
// Purpose: Dual negative-edge J-K flip-flop with preset and clear
// Assumes: edge_clock and all other inputs are synchronous to core_clk_in
// Notes:   Edges of edge_clock are found by sampling; outputs lag one cycle

`timescale 1ns/1ps

// Overview of operation
// - Two flops share no control input
// - Preset low alone forces true high
// - Both low gives both outputs high
// - Without forcing, state changes only on falling edge_clock
// - Falling edge: hold, set or reset
// - Both inputs high toggles every falling edge
// - Clock high accepts inputs, outputs unchanged
// - Build with clear, preset, or both
// - Hold keeps prior state; complement tracks
module djkff_top
	import djkff_pkg::*;
#(
	parameter djkff_pkg::djkff_opt_e BUILD = djkff_pkg::DJKFF_OPT_BOTH
)
(
	// Clock and reset
	input  wire logic core_clk_in,
	input  wire logic rst_in,
	// Flip-flop A inputs
	input  wire logic a_edge_clock_in,
	input  wire logic a_set_input_in,
	input  wire logic a_reset_input_in,
	input  wire logic a_async_set_n_in,
	input  wire logic a_async_clear_n_in,
	// Flip-flop B inputs
	input  wire logic b_edge_clock_in,
	input  wire logic b_set_input_in,
	input  wire logic b_reset_input_in,
	input  wire logic b_async_set_n_in,
	input  wire logic b_async_clear_n_in,
	// Flip-flop A outputs
	output logic      a_true_out,
	output logic      a_comp_out,
	// Flip-flop B outputs
	output logic      b_true_out,
	output logic      b_comp_out
);

	// ===========================================================
	// Input gathering
	// ===========================================================
	logic [1:0] prev_clk;
	wire  [1:0] edge_clock;
	wire  [1:0] set_input;
	wire  [1:0] reset_input;
	wire  [1:0] raw_set_n;
	wire  [1:0] raw_clear_n;
	wire  [1:0] eff_set_n;
	wire  [1:0] eff_clear_n;
	wire  [1:0] fall;
	wire  [1:0] true_q;
	wire  [1:0] comp_q;
	wire        has_preset;
	wire        has_clear;

	// Per-flop input vectors, nothing shared across flops
	// separate controls
	assign edge_clock  = {b_edge_clock_in, a_edge_clock_in};
	assign set_input   = {b_set_input_in, a_set_input_in};
	assign reset_input = {b_reset_input_in, a_reset_input_in};
	assign raw_set_n   = {b_async_set_n_in, a_async_set_n_in};
	assign raw_clear_n = {b_async_clear_n_in, a_async_clear_n_in};

	// Build option strips absent forcing inputs
	// build options
	assign has_preset  = BUILD[DJKFF_OPT_PRESET_BIT];
	assign has_clear   = BUILD[DJKFF_OPT_CLEAR_BIT];

	// ===========================================================
	// Edge detection of edge_clock
	// ===========================================================
	// Last sampled level of each edge_clock
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			prev_clk <= {DJKFF_NUM_FLOPS{DJKFF_CLK_RST}};
		else
			prev_clk <= edge_clock;
	end

	// ===========================================================
	// Per-flop storage
	// ===========================================================
	genvar ch;
	generate
		for (ch = 0; ch < DJKFF_NUM_FLOPS; ch = ch + 1)
		begin : g_flop
			// Absent inputs read as inactive
			assign eff_set_n[ch]   = has_preset ? raw_set_n[ch] : DJKFF_INACTIVE;
			assign eff_clear_n[ch] = has_clear ? raw_clear_n[ch] : DJKFF_INACTIVE;

			// Only a high-to-low step of edge_clock counts
			// falling edge
			assign fall[ch] = prev_clk[ch] && !edge_clock[ch];

			djkff_cell u_cell
			(
				.core_clk_in      (core_clk_in),
				.rst_in           (rst_in),
				.fall_in          (fall[ch]),
				.set_input_in     (set_input[ch]),
				.reset_input_in   (reset_input[ch]),
				.async_set_n_in   (eff_set_n[ch]),
				.async_clear_n_in (eff_clear_n[ch]),
				.true_out         (true_q[ch]),
				.comp_out         (comp_q[ch])
			);
		end
	endgenerate

	// Output mapping straight from the cell registers
	assign a_true_out = true_q[0];
	assign a_comp_out = comp_q[0];
	assign b_true_out = true_q[1];
	assign b_comp_out = comp_q[1];

	// ===========================================================
	// Assertions
	// ===========================================================
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);

	wire [1:0] idle;
	assign idle = eff_set_n & eff_clear_n;

	property p_preset;
		(!eff_set_n[0] && eff_clear_n[0]) |=> (true_q[0] && !comp_q[0]);
	endproperty
	a_preset: assert property (p_preset) else $error("preset did not force high");

	property p_clear;
		(eff_set_n[1] && !eff_clear_n[1]) |=> (!true_q[1] && comp_q[1]);
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not force low");

	property p_both;
		(!eff_set_n[0] && !eff_clear_n[0]) ##1 idle[0] |=> (comp_q[0] == !true_q[0]);
	endproperty
	a_both: assert property (p_both) else $error("both-low state persisted");

	property p_both_high;
		(!eff_set_n[1] && !eff_clear_n[1]) |=> (true_q[1] && comp_q[1]);
	endproperty
	a_both_high: assert property (p_both_high) else $error("both-low outputs not high");

	property p_no_edge;
		(idle[0] && $past(idle[0]) && !fall[0]) |=> ($stable(true_q[0]) && $stable(comp_q[0]));
	endproperty
	a_no_edge: assert property (p_no_edge) else $error("change without falling edge");

	property p_clk_high;
		(idle[1] && edge_clock[1]) |=> $stable(true_q[1]);
	endproperty
	a_clk_high: assert property (p_clk_high) else $error("output moved with clock high");

	property p_set_reset;
		(idle[0] && fall[0] && (set_input[0] != reset_input[0]))
			|=> (true_q[0] == $past(set_input[0]));
	endproperty
	a_set_reset: assert property (p_set_reset) else $error("set or reset not applied");

	property p_hold;
		(idle[1] && fall[1] && !set_input[1] && !reset_input[1]) |=> $stable(true_q[1]);
	endproperty
	a_hold: assert property (p_hold) else $error("hold lost prior state");

	property p_toggle;
		(idle[0] && fall[0] && set_input[0] && reset_input[0])
			|=> (true_q[0] != $past(true_q[0]) && comp_q[0] == !true_q[0]);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle did not invert");

	property p_indep;
		(idle[1] && !fall[1] && (fall[0] || !idle[0])) |=> $stable(true_q[1]);
	endproperty
	a_indep: assert property (p_indep) else $error("flop B followed flop A");

	property p_option;
		(!has_preset |-> (eff_set_n == 2'h3)) and (!has_clear |-> (eff_clear_n == 2'h3));
	endproperty
	a_option: assert property (p_option) else $error("absent input not inactive");

	// Complement, other-flop forcing and rising-edge checks
	property p_comp_track;
		$past(idle[1]) |-> (comp_q[1] == !true_q[1]);
	endproperty
	a_comp_track: assert property (p_comp_track) else $error("complement lost");

	property p_preset_b;
		(!eff_set_n[1] && eff_clear_n[1]) |=> (true_q[1] && !comp_q[1]);
	endproperty
	a_preset_b: assert property (p_preset_b) else $error("preset B not forced");

	property p_clear_a;
		(eff_set_n[0] && !eff_clear_n[0]) |=> (!true_q[0] && comp_q[0]);
	endproperty
	a_clear_a: assert property (p_clear_a) else $error("clear A not forced");

	property p_rise;
		(idle[0] && edge_clock[0] && !prev_clk[0]) |=> $stable(true_q[0]);
	endproperty
	a_rise: assert property (p_rise) else $error("rising edge moved output");

	// Main scenarios
	c_toggle: cover property (idle[0] && fall[0] && set_input[0] && reset_input[0]);
	c_hold:   cover property (idle[1] && fall[1] && !set_input[1] && !reset_input[1]);
	c_preset: cover property (!eff_set_n[0] && eff_clear_n[0]);
	c_clear:  cover property (eff_set_n[1] && !eff_clear_n[1]);
	c_both:   cover property (!eff_set_n[0] && !eff_clear_n[0] ##1 idle[0]);

endmodule

// ### tb/djkff_drv.sv
// Purpose: Surrounding logic that clocks one flop and drives its J/K
// Assumes: Requests are made at core_clk_in falling edges
// Notes:   J/K are held until the fall has been sampled

`timescale 1ns/1ps

module djkff_drv
(
	// Clock
	input  wire logic core_clk_in,
	// Flop controls
	output logic      edge_clock_out,
	output logic      set_out,
	output logic      reset_out
);
	// ===========================================================
	// Idle levels at time zero
	initial
	begin
		edge_clock_out = 1'b0;
		set_out = 1'b0;
		reset_out = 1'b0;
	end

	task automatic fall(input logic j, input logic k);
		@(negedge core_clk_in);
		edge_clock_out = 1'b1;
		set_out = j;
		reset_out = k;
		@(negedge core_clk_in);
		edge_clock_out = 1'b0;
		@(posedge core_clk_in);
	endtask
endmodule

// ### tb/testbench.sv
// Purpose: Self-checking bench for the dual J-K flip-flop
// Assumes: Outputs change at the core edge that samples a fall or forcing
// Notes:   Clear-only and preset-only builds share flop A inputs

`timescale 1ns/1ps

module testbench;
	import djkff_pkg::*;
	logic        core_clk_in;
	logic        rst_in;
	logic        a_ps_n, a_cl_n, b_ps_n, b_cl_n;
	logic        a_ck, a_j, a_k, b_ck, b_j, b_k;
	logic        a_t, a_c, b_t, b_c, x_t, x_c, y_t, y_c;
	logic        ra, rb, rx, ry;
	logic [31:0] r;
	logic [7:0]  q[$];
	event        chk_ev;
	int          num_errors, check_count, cyc;

	// ===========================================================
	// Drivers and designs
	djkff_drv drv_a (.core_clk_in(core_clk_in), .edge_clock_out(a_ck), .set_out(a_j),
		.reset_out(a_k));
	djkff_drv drv_b (.core_clk_in(core_clk_in), .edge_clock_out(b_ck), .set_out(b_j),
		.reset_out(b_k));
	djkff_top DUT (.core_clk_in(core_clk_in), .rst_in(rst_in), .a_edge_clock_in(a_ck),
		.a_set_input_in(a_j), .a_reset_input_in(a_k), .a_async_set_n_in(a_ps_n),
		.a_async_clear_n_in(a_cl_n), .b_edge_clock_in(b_ck), .b_set_input_in(b_j),
		.b_reset_input_in(b_k), .b_async_set_n_in(b_ps_n), .b_async_clear_n_in(b_cl_n),
		.a_true_out(a_t), .a_comp_out(a_c), .b_true_out(b_t), .b_comp_out(b_c));
	djkff_top #(.BUILD(DJKFF_OPT_CLEAR)) DUT_clr (.core_clk_in(core_clk_in),
		.rst_in(rst_in), .a_edge_clock_in(a_ck), .a_set_input_in(a_j),
		.a_reset_input_in(a_k), .a_async_set_n_in(a_ps_n), .a_async_clear_n_in(a_cl_n),
		.b_edge_clock_in(b_ck), .b_set_input_in(b_j), .b_reset_input_in(b_k),
		.b_async_set_n_in(b_ps_n), .b_async_clear_n_in(b_cl_n), .a_true_out(x_t),
		.a_comp_out(x_c), .b_true_out(), .b_comp_out());
	djkff_top #(.BUILD(DJKFF_OPT_PRESET)) DUT_pre (.core_clk_in(core_clk_in),
		.rst_in(rst_in), .a_edge_clock_in(a_ck), .a_set_input_in(a_j),
		.a_reset_input_in(a_k), .a_async_set_n_in(a_ps_n), .a_async_clear_n_in(a_cl_n),
		.b_edge_clock_in(b_ck), .b_set_input_in(b_j), .b_reset_input_in(b_k),
		.b_async_set_n_in(b_ps_n), .b_async_clear_n_in(b_cl_n), .a_true_out(y_t),
		.a_comp_out(y_c), .b_true_out(), .b_comp_out());

	// ===========================================================
	// Clock and hang guard
	initial
	begin
		core_clk_in = 1'b0;
		forever #20 core_clk_in = ~core_clk_in;
	end
	always @(posedge core_clk_in)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			num_errors++;
			results();
		end
	end

	// ===========================================================
	// Reference, notes and compare
	function automatic logic nxt(input logic s, input logic j, input logic k);
		return (j & k) ? ~s : (j ? 1'b1 : (k ? 1'b0 : s));
	endfunction
	function automatic logic [7:0] ex();
		return {ra, ~ra, rb, ~rb, rx, ~rx, ry, ~ry};
	endfunction
	task automatic note(input logic [7:0] e);
		q.push_back(e);
		->chk_ev;
	endtask
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] %s expected %b seen %b", n, e, g);
		end
	endtask
	// Watcher takes the oldest note
	always @(chk_ev)
		cmp("outputs", q.pop_front(), {a_t, a_c, b_t, b_c, x_t, x_c, y_t, y_c});
	task automatic results();
		if (num_errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One fall on both flops; fa, fb, fx, fy mark a forced flop
	task automatic pulse(input logic ja, ka, jb, kb, fa, fb, fx, fy);
		fork
			drv_a.fall(ja, ka);
			drv_b.fall(jb, kb);
			// Rising edge_clock has been sampled: nothing may move yet
			begin
				@(negedge core_clk_in);
				@(posedge core_clk_in);
				#1;
				note(ex());
			end
		join
		#1;
		ra = fa ? ra : nxt(ra, ja, ka);
		rb = fb ? rb : nxt(rb, jb, kb);
		rx = fx ? rx : nxt(rx, ja, ka);
		ry = fy ? ry : nxt(ry, ja, ka);
		note(ex());
		@(negedge core_clk_in);
		note(ex());
	endtask

	// ===========================================================
	// Main sequence
	initial
	begin
		rst_in = 1'b1;
		{a_ps_n, a_cl_n, b_ps_n, b_cl_n} = {4{DJKFF_INACTIVE}};
		ra = DJKFF_TRUE_RST;
		rb = DJKFF_TRUE_RST;
		rx = DJKFF_TRUE_RST;
		ry = DJKFF_TRUE_RST;
		void'($urandom(92858));
		repeat (16) @(negedge core_clk_in);
		rst_in = 1'b0;
		note(ex());
		for (int i = 0; i < 4; i++)
			pulse(i[1], i[0], i[0], i[1], 1'b0, 1'b0, 1'b0, 1'b0);
		repeat (3) pulse(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		repeat (40)
		begin
			r = $urandom;
			pulse(r[0], r[1], r[2], r[3], 1'b0, 1'b0, 1'b0, 1'b0);
		end
		// Preset refuses falls; clear-only build ignores it
		{a_ps_n, b_ps_n} = 2'b00;
		{ra, rb, ry} = 3'b111;
		pulse(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
		// Clear refuses falls; preset-only build ignores it
		{a_ps_n, b_ps_n, a_cl_n, b_cl_n} = 4'b1100;
		{ra, rb, rx} = 3'b000;
		pulse(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
		a_ps_n = 1'b0;
		repeat (2) @(negedge core_clk_in);
		note(8'b11010110);
		{a_ps_n, b_ps_n, a_cl_n, b_cl_n} = 4'b1111;
		ra = 1'b1;
		repeat (2) @(negedge core_clk_in);
		note(ex());
		pulse(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		repeat (2) @(negedge core_clk_in);
		results();
	end
endmodule
